/* File: include/vsc_consts.svh */
// Register indices, field positions, reset values and bus codes of the slicer and clamp bank.
// Behaviour
// - Clamp disable bits 6,5,4 turn channel clamping off at 1; all reset 0.
// - Clamp test-select bit 3 selects test at 1, normal at 0; resets normal.
// - Missing double-word byte is filled with programmable 8-bit value, reset A0h.
// - Bits 7-6 pick blanking low-pass filter: 00 off, 01/10/11 types one-three.
// - Bits 5-0 hold sliced identification code for output; reset 22h.
// - Control-two bit 7 at 1 embeds video-loss indication in the output stream.
// - Sync-removal bit at 1 outputs sync-removed data, at 0 raw data.
// - Widescreen decoding happens only while decode enable is 1; disabled after reset.
// - Bits 4-0 give ancillary header framing code for sliced packets; reset 11h.
// - Ancillary packets of sliced data are emitted only while bit 7 is 1.
// - Active-period bit at 1 outputs sliced data while horizontal active is high.
// - Task select bit picks task A codes at 1, task B codes at 0.
// - Five-bit field picks odd-field caption decoding line; reset 15h.
// - Eight-bit register holds the slicer's initial slice level; reset 72h.
// - Read-only bit 7 reads 1 on widescreen check error, else 0.
// - Read-only bit reports widescreen detection field: 0 odd, 1 even.
// - Fourteen-bit widescreen word reads as bits 13-8 and bits 7-0.
// - Status bits 5,4,3 report weak, standard and non-interlaced signal.
// - Status bits 2,1,0 report widescreen, extended data and caption detected.
// - Read-only register shows the measured horizontal line frequency indicator.
// - Clamp mode bits 3-2: 0 sync top, 1 auto, 2 pedestal; reset 1.
// - Slice level select bits 1-0: 0 low, 1 medium, 2 high; reset 1.
`ifndef VSC_CONSTS_SVH
`define VSC_CONSTS_SVH

`define VSC_IDX_CLAMP_CONTROL_TWO      8'h31
`define VSC_IDX_MISSING_BYTE_FILL      8'h32
`define VSC_IDX_BLANKING_CONTROL_ONE   8'h33
`define VSC_IDX_BLANKING_CONTROL_TWO   8'h34
`define VSC_IDX_ANCILLARY_OUTPUT       8'h35
`define VSC_IDX_INITIAL_SLICE          8'h36
`define VSC_IDX_WIDESCREEN_HIGH        8'h37
`define VSC_IDX_WIDESCREEN_LOW         8'h38
`define VSC_IDX_SIGNAL_STATUS          8'h39
`define VSC_IDX_LINE_FREQUENCY         8'h3A
`define VSC_IDX_CLAMP_MODE             8'h3B

`define VSC_RST_CLAMP_CONTROL_TWO      8'h00
`define VSC_RST_MISSING_BYTE_FILL      8'hA0
`define VSC_RST_BLANKING_CONTROL_ONE   8'h22
`define VSC_RST_BLANKING_CONTROL_TWO   8'h11
`define VSC_RST_ANCILLARY_OUTPUT       8'h15
`define VSC_RST_INITIAL_SLICE          8'h72
`define VSC_RST_CLAMP_MODE             4'h5

`define VSC_POS_LUMA_DISABLE           6
`define VSC_POS_CHROMA_DISABLE         5
`define VSC_POS_THIRD_DISABLE          4
`define VSC_POS_TEST_SELECT            3
`define VSC_POS_DEBUG_CONTROL          7
`define VSC_POS_FILTER_CONTROL         2
`define VSC_POS_CURRENT_ONE            1
`define VSC_POS_CURRENT_TWO            0
`define VSC_POS_LOSS_ENABLE            7
`define VSC_POS_SYNC_REMOVAL           6
`define VSC_POS_WIDESCREEN_ENABLE      5
`define VSC_POS_ANCILLARY_ENABLE       7
`define VSC_POS_ACTIVE_PERIOD          6
`define VSC_POS_TASK_SELECT            5

`define VSC_RESP_OKAY                  2'h0
`define VSC_RESP_SLVERR                2'h2

`endif

/* File: include/vsc_pkg.sv */
// Types shared by the slicer and clamp register bank.
package vsc_pkg;

  typedef struct packed {
    logic [7:0] clamp_two;
    logic [7:0] fill;
    logic [7:0] blank_one;
    logic [7:0] blank_two;
    logic [7:0] anc_ctl;
    logic [7:0] slice;
    logic [3:0] clamp_mode;
    logic       check_error;
    logic       field_flag;
    logic [13:0] ws_word;
    logic [5:0] status;
    logic [7:0] line_freq;
    logic       active_window;
    logic       aw_got;
    logic [7:0] aw_idx;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_lane;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } vsc_state_t;

endpackage

/* File: logic/vsc_regs.sv */
// AXI4-Lite register bank for clamp control, blanking slicer setup and widescreen status.
`timescale 1ns/1ns
`include "vsc_consts.svh"
module vsc_regs #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Results from the decoding logic, same clock.
  input  wire logic              widescreen_strobe,
  input  wire logic [13:0]       widescreen_word,
  input  wire logic              widescreen_check_error,
  input  wire logic              widescreen_field_flag,
  input  wire logic              weak_signal_flag,
  input  wire logic              standard_signal_flag,
  input  wire logic              progressive_signal_flag,
  input  wire logic              extended_data_detected,
  input  wire logic              caption_detected,
  input  wire logic [7:0]        line_frequency_value,
  input  wire logic              horizontal_active,
  // Clamp controls.
  output logic                   clamp_debug_control,
  output logic                   luma_clamp_disable,
  output logic                   chroma_clamp_disable,
  output logic                   third_channel_clamp_disable,
  output logic                   clamp_test_select,
  output logic                   clamp_filter_control,
  output logic                   clamp_current_one,
  output logic                   clamp_current_two,
  output logic [1:0]             clamp_mode_field,
  // Slicer and ancillary controls.
  output logic [7:0]             missing_byte_value,
  output logic [1:0]             blanking_filter_select,
  output logic [5:0]             sliced_ident_code,
  output logic                   embedded_loss_enable,
  output logic                   sync_removal_select,
  output logic                   widescreen_decode_enable,
  output logic [4:0]             ancillary_framing_code,
  output logic                   ancillary_output_enable,
  output logic                   active_period_output,
  output logic                   active_output_window,
  output logic                   task_code_select,
  output logic [4:0]             odd_caption_line,
  output logic [7:0]             initial_slice_level,
  output logic [1:0]             slice_level_select
);
  import vsc_pkg::*;

  vsc_state_t state_ff;
  vsc_state_t nxt_state;
  logic       widescreen_detected;

  always_comb begin
    logic [7:0] rd_idx;
    logic       do_write;
    nxt_state = state_ff;
    rd_idx = s_axi_araddr[9:2];
    do_write = 1'b0;
    // Decoded results enter only from the decoding side, never from the bus.
    nxt_state.status[5] = weak_signal_flag;
    nxt_state.status[4] = standard_signal_flag;
    nxt_state.status[3] = progressive_signal_flag;
    nxt_state.status[1] = extended_data_detected;
    nxt_state.status[0] = caption_detected;
    nxt_state.line_freq = line_frequency_value;
    if (widescreen_strobe && state_ff.blank_two[`VSC_POS_WIDESCREEN_ENABLE]) begin
      nxt_state.ws_word     = widescreen_word;
      nxt_state.check_error = widescreen_check_error;
      nxt_state.field_flag  = widescreen_field_flag;
      nxt_state.status[2]   = 1'b1;
    end
    // Losing the enable drops the detected flag so stale words are not reported as live.
    if (!state_ff.blank_two[`VSC_POS_WIDESCREEN_ENABLE]) begin
      nxt_state.status[2] = 1'b0;
    end
    nxt_state.active_window = state_ff.anc_ctl[`VSC_POS_ACTIVE_PERIOD] & horizontal_active;
    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && state_ff.awready) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && state_ff.wready) begin
      nxt_state.w_got  = 1'b1;
      nxt_state.w_data = s_axi_wdata[7:0];
      nxt_state.w_lane = s_axi_wstrb[0];
    end
    if (nxt_state.aw_got && nxt_state.w_got && !state_ff.bvalid) begin
      do_write = 1'b1;
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = `VSC_RESP_OKAY;
    end
    if (do_write) begin
      unique case (nxt_state.aw_idx)
        `VSC_IDX_CLAMP_CONTROL_TWO: begin
          if (nxt_state.w_lane) nxt_state.clamp_two = nxt_state.w_data;
        end
        `VSC_IDX_MISSING_BYTE_FILL: begin
          if (nxt_state.w_lane) nxt_state.fill = nxt_state.w_data;
        end
        `VSC_IDX_BLANKING_CONTROL_ONE: begin
          if (nxt_state.w_lane) nxt_state.blank_one = nxt_state.w_data;
        end
        `VSC_IDX_BLANKING_CONTROL_TWO: begin
          if (nxt_state.w_lane) nxt_state.blank_two = nxt_state.w_data;
        end
        `VSC_IDX_ANCILLARY_OUTPUT: begin
          if (nxt_state.w_lane) nxt_state.anc_ctl = nxt_state.w_data;
        end
        `VSC_IDX_INITIAL_SLICE: begin
          if (nxt_state.w_lane) nxt_state.slice = nxt_state.w_data;
        end
        `VSC_IDX_CLAMP_MODE: begin
          if (nxt_state.w_lane) nxt_state.clamp_mode = nxt_state.w_data[3:0];
        end
        `VSC_IDX_WIDESCREEN_HIGH, `VSC_IDX_WIDESCREEN_LOW,
        `VSC_IDX_SIGNAL_STATUS, `VSC_IDX_LINE_FREQUENCY: begin
          nxt_state.bresp = `VSC_RESP_OKAY;
        end
        default: begin
          nxt_state.bresp = `VSC_RESP_SLVERR;
        end
      endcase
    end
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    // One read at a time; arready stays low until the answer is taken.
    if (s_axi_arvalid && state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp  = `VSC_RESP_OKAY;
      unique case (rd_idx)
        `VSC_IDX_CLAMP_CONTROL_TWO:    nxt_state.rdata = state_ff.clamp_two;
        `VSC_IDX_MISSING_BYTE_FILL:    nxt_state.rdata = state_ff.fill;
        `VSC_IDX_BLANKING_CONTROL_ONE: nxt_state.rdata = state_ff.blank_one;
        `VSC_IDX_BLANKING_CONTROL_TWO: nxt_state.rdata = state_ff.blank_two;
        `VSC_IDX_ANCILLARY_OUTPUT:     nxt_state.rdata = state_ff.anc_ctl;
        `VSC_IDX_INITIAL_SLICE:        nxt_state.rdata = state_ff.slice;
        `VSC_IDX_WIDESCREEN_HIGH:      nxt_state.rdata = {state_ff.check_error,
                                                          state_ff.field_flag,
                                                          state_ff.ws_word[13:8]};
        `VSC_IDX_WIDESCREEN_LOW:       nxt_state.rdata = state_ff.ws_word[7:0];
        `VSC_IDX_SIGNAL_STATUS:        nxt_state.rdata = {2'h0, state_ff.status[5:3],
                                                          widescreen_detected,
                                                          state_ff.status[1:0]};
        `VSC_IDX_LINE_FREQUENCY:       nxt_state.rdata = state_ff.line_freq;
        `VSC_IDX_CLAMP_MODE:           nxt_state.rdata = {4'h0, state_ff.clamp_mode};
        default: begin
          nxt_state.rdata = 8'h00;
          nxt_state.rresp = `VSC_RESP_SLVERR;
        end
      endcase
    end
    if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
    nxt_state.wready  = !nxt_state.w_got && !nxt_state.bvalid;
    nxt_state.arready = !nxt_state.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0;
      state_ff.clamp_two  <= `VSC_RST_CLAMP_CONTROL_TWO;
      state_ff.fill       <= `VSC_RST_MISSING_BYTE_FILL;
      state_ff.blank_one  <= `VSC_RST_BLANKING_CONTROL_ONE;
      state_ff.blank_two  <= `VSC_RST_BLANKING_CONTROL_TWO;
      state_ff.anc_ctl    <= `VSC_RST_ANCILLARY_OUTPUT;
      state_ff.slice      <= `VSC_RST_INITIAL_SLICE;
      state_ff.clamp_mode <= `VSC_RST_CLAMP_MODE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign widescreen_detected = state_ff.status[2];

  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready  = state_ff.wready;
  assign s_axi_bvalid  = state_ff.bvalid;
  assign s_axi_bresp   = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid  = state_ff.rvalid;
  assign s_axi_rresp   = state_ff.rresp;
  assign s_axi_rdata   = {24'h000000, state_ff.rdata};

  assign clamp_debug_control         = state_ff.clamp_two[`VSC_POS_DEBUG_CONTROL];
  assign luma_clamp_disable          = state_ff.clamp_two[`VSC_POS_LUMA_DISABLE];
  assign chroma_clamp_disable        = state_ff.clamp_two[`VSC_POS_CHROMA_DISABLE];
  assign third_channel_clamp_disable = state_ff.clamp_two[`VSC_POS_THIRD_DISABLE];
  assign clamp_test_select           = state_ff.clamp_two[`VSC_POS_TEST_SELECT];
  assign clamp_filter_control        = state_ff.clamp_two[`VSC_POS_FILTER_CONTROL];
  assign clamp_current_one           = state_ff.clamp_two[`VSC_POS_CURRENT_ONE];
  assign clamp_current_two           = state_ff.clamp_two[`VSC_POS_CURRENT_TWO];
  assign clamp_mode_field            = state_ff.clamp_mode[3:2];
  assign slice_level_select          = state_ff.clamp_mode[1:0];
  assign missing_byte_value          = state_ff.fill;
  assign blanking_filter_select      = state_ff.blank_one[7:6];
  assign sliced_ident_code           = state_ff.blank_one[5:0];
  assign embedded_loss_enable        = state_ff.blank_two[`VSC_POS_LOSS_ENABLE];
  assign sync_removal_select         = state_ff.blank_two[`VSC_POS_SYNC_REMOVAL];
  assign widescreen_decode_enable    = state_ff.blank_two[`VSC_POS_WIDESCREEN_ENABLE];
  assign ancillary_framing_code      = state_ff.blank_two[4:0];
  assign ancillary_output_enable     = state_ff.anc_ctl[`VSC_POS_ANCILLARY_ENABLE];
  assign active_period_output        = state_ff.anc_ctl[`VSC_POS_ACTIVE_PERIOD];
  assign active_output_window        = state_ff.active_window;
  assign task_code_select            = state_ff.anc_ctl[`VSC_POS_TASK_SELECT];
  assign odd_caption_line            = state_ff.anc_ctl[4:0];
  assign initial_slice_level         = state_ff.slice;

endmodule // vsc_regs

/* File: dv/vsc_regs_properties.sv */
// Concurrent checks of the slicer and clamp register bank at its ports.
`timescale 1ns/1ns
`include "vsc_consts.svh"
module vsc_regs_checker #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and write channels.
  input wire logic              aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic [1:0]        s_axi_bresp,
  // Control outputs.
  input wire logic              luma_clamp_disable, chroma_clamp_disable,
  input wire logic              third_channel_clamp_disable, clamp_test_select,
  input wire logic              embedded_loss_enable, sync_removal_select,
  input wire logic              widescreen_decode_enable, ancillary_output_enable,
  input wire logic              active_period_output, task_code_select,
  input wire logic [7:0]        missing_byte_value, initial_slice_level,
  input wire logic [5:0]        sliced_ident_code,
  input wire logic [4:0]        ancillary_framing_code, odd_caption_line,
  input wire logic [1:0]        blanking_filter_select, clamp_mode_field, slice_level_select,
  // Spare clamp bits and the active-period window.
  input wire logic              clamp_debug_control, clamp_filter_control,
  input wire logic              clamp_current_one, clamp_current_two,
  input wire logic              horizontal_active, active_output_window
);
  logic [7:0] wi_ff;
  logic [7:0] wd_ff;
  logic       ws_ff;
  wire [51:0] cfg = {clamp_debug_control, clamp_filter_control, clamp_current_one,
    clamp_current_two, luma_clamp_disable, chroma_clamp_disable, third_channel_clamp_disable,
    clamp_test_select, embedded_loss_enable, sync_removal_select, widescreen_decode_enable,
    ancillary_output_enable, active_period_output, task_code_select, missing_byte_value,
    initial_slice_level, sliced_ident_code, ancillary_framing_code, odd_caption_line,
    blanking_filter_select, clamp_mode_field, slice_level_select};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data may be taken on different edges, so each is kept until the response.
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wi_ff <= s_axi_awaddr[9:2];
    if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) ws_ff <= s_axi_wstrb[0];
  end
  sequence s_wr(logic [7:0] idx);
    $rose(s_axi_bvalid) && ws_ff && wi_ff == idx;
  endsequence
  property p_clamp;
    s_wr(`VSC_IDX_CLAMP_CONTROL_TWO) |-> {clamp_debug_control, luma_clamp_disable,
      chroma_clamp_disable, third_channel_clamp_disable, clamp_test_select,
      clamp_filter_control, clamp_current_one, clamp_current_two} == wd_ff;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp disable mismatch");
  property p_test; s_wr(`VSC_IDX_CLAMP_CONTROL_TWO) |-> clamp_test_select == wd_ff[3]; endproperty
  a_test: assert property (p_test) else $error("test select mismatch");
  property p_fill; s_wr(`VSC_IDX_MISSING_BYTE_FILL) |-> missing_byte_value == wd_ff; endproperty
  a_fill: assert property (p_fill) else $error("fill value mismatch");
  property p_blank1;
    s_wr(`VSC_IDX_BLANKING_CONTROL_ONE) |-> {blanking_filter_select, sliced_ident_code} == wd_ff;
  endproperty
  a_blank1: assert property (p_blank1) else $error("blanking one mismatch");
  property p_blank2;
    s_wr(`VSC_IDX_BLANKING_CONTROL_TWO) |-> {embedded_loss_enable, sync_removal_select,
      widescreen_decode_enable, ancillary_framing_code} == wd_ff;
  endproperty
  a_blank2: assert property (p_blank2) else $error("blanking two mismatch");
  property p_anc;
    s_wr(`VSC_IDX_ANCILLARY_OUTPUT) |-> {ancillary_output_enable, active_period_output,
      task_code_select, odd_caption_line} == wd_ff;
  endproperty
  a_anc: assert property (p_anc) else $error("ancillary mismatch");
  property p_slice; s_wr(`VSC_IDX_INITIAL_SLICE) |-> initial_slice_level == wd_ff; endproperty
  a_slice: assert property (p_slice) else $error("slice level mismatch");
  property p_mode;
    s_wr(`VSC_IDX_CLAMP_MODE) |-> {clamp_mode_field, slice_level_select} == wd_ff[3:0];
  endproperty
  a_mode: assert property (p_mode) else $error("clamp mode mismatch");
  property p_ro;
    $rose(s_axi_bvalid) && wi_ff inside {[8'h37:8'h3A]} |-> s_axi_bresp == `VSC_RESP_OKAY;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write response wrong");
  property p_hold; !$rose(s_axi_bvalid) |-> $stable(cfg); endproperty
  a_hold: assert property (p_hold) else $error("controls changed without a write");
  property p_window;
    active_output_window == $past(active_period_output & horizontal_active);
  endproperty
  a_window: assert property (p_window) else $error("active window mismatch");
endmodule // vsc_regs_checker
bind vsc_regs vsc_regs_checker #(.ADDR_W(ADDR_W)) u_checker (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bresp(s_axi_bresp),
  .luma_clamp_disable(luma_clamp_disable), .chroma_clamp_disable(chroma_clamp_disable),
  .third_channel_clamp_disable(third_channel_clamp_disable),
  .clamp_test_select(clamp_test_select), .embedded_loss_enable(embedded_loss_enable),
  .sync_removal_select(sync_removal_select), .widescreen_decode_enable(widescreen_decode_enable),
  .ancillary_output_enable(ancillary_output_enable), .task_code_select(task_code_select),
  .active_period_output(active_period_output), .missing_byte_value(missing_byte_value),
  .initial_slice_level(initial_slice_level), .sliced_ident_code(sliced_ident_code),
  .ancillary_framing_code(ancillary_framing_code), .odd_caption_line(odd_caption_line),
  .blanking_filter_select(blanking_filter_select), .clamp_mode_field(clamp_mode_field),
  .slice_level_select(slice_level_select), .clamp_debug_control(clamp_debug_control),
  .clamp_filter_control(clamp_filter_control), .clamp_current_one(clamp_current_one),
  .clamp_current_two(clamp_current_two), .horizontal_active(horizontal_active),
  .active_output_window(active_output_window));

/* File: dv/vbi_slicer_clamp_regs_test.sv */
// Self-checking bench of the slicer and clamp register bank.
`timescale 1ns/1ns
`include "vsc_consts.svh"
module vbi_slicer_clamp_regs_test;
  localparam logic [1:0] OK = `VSC_RESP_OKAY;
  localparam logic [1:0] BAD = `VSC_RESP_SLVERR;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, strobe, werr, wfld, hact;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [13:0] wword;
  logic [4:0]  fl;
  logic [7:0]  freq;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          mismatches, checks_done;
  vsc_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .widescreen_strobe(strobe), .widescreen_word(wword),
    .widescreen_check_error(werr), .widescreen_field_flag(wfld), .weak_signal_flag(fl[4]),
    .standard_signal_flag(fl[3]), .progressive_signal_flag(fl[2]),
    .extended_data_detected(fl[1]), .caption_detected(fl[0]), .line_frequency_value(freq),
    .horizontal_active(hact), .clamp_debug_control(), .luma_clamp_disable(),
    .chroma_clamp_disable(), .third_channel_clamp_disable(), .clamp_test_select(),
    .clamp_filter_control(), .clamp_current_one(), .clamp_current_two(), .clamp_mode_field(),
    .missing_byte_value(), .blanking_filter_select(), .sliced_ident_code(),
    .embedded_loss_enable(), .sync_removal_select(), .widescreen_decode_enable(),
    .ancillary_framing_code(), .ancillary_output_enable(), .active_period_output(),
    .active_output_window(), .task_code_select(), .odd_caption_line(), .initial_slice_level(),
    .slice_level_select());
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Readies are registered, so the level at the falling edge is what the next rising edge sees.
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic [31:0] v;
    logic ah, wh, bh;
    v = $urandom;
    v[7:0] = d;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] r);
    logic ah, rh;
    rq.push_back({r, 24'h0, e});
    @(posedge aclk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic pulse();
    @(posedge aclk);
    {werr, wfld, wword} <= 16'($urandom);
    strobe <= 1'b1;
    @(posedge aclk);
    strobe <= 1'b0;
    @(posedge aclk);
  endtask
  always @(negedge aclk) begin
    if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
  end
  always @(posedge aclk) hact <= 1'($urandom);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
  initial begin
    logic [7:0] ix[7], rv[7], mk[7], d;
    ix = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h3B};
    rv = '{8'h00, 8'hA0, 8'h22, 8'h11, 8'h15, 8'h72, 8'h05};
    mk = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
    void'($urandom(32'h2BFA));
    {awvalid, wvalid, bready, arvalid, rready, strobe, werr, wfld} = 8'h00;
    {awaddr, araddr, wdata, wstrb, wword, fl} = '0;
    freq = 8'($urandom);
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ix[k]) rd(ix[k], rv[k], OK);
    repeat (3) begin
      @(posedge aclk);
      fl <= 5'($urandom);
      freq <= 8'($urandom);
      @(posedge aclk);
      rd(`VSC_IDX_SIGNAL_STATUS, {2'h0, fl[4:2], 1'b0, fl[1:0]}, OK);
      rd(`VSC_IDX_LINE_FREQUENCY, freq, OK);
    end
    pulse();
    rd(`VSC_IDX_WIDESCREEN_LOW, 8'h00, OK);
    wr(`VSC_IDX_BLANKING_CONTROL_TWO, 8'h31, 4'h1, OK);
    pulse();
    for (int k = 0; k < 2; k++) begin
      rd(`VSC_IDX_WIDESCREEN_HIGH, {werr, wfld, wword[13:8]}, OK);
      rd(`VSC_IDX_WIDESCREEN_LOW, wword[7:0], OK);
      rd(`VSC_IDX_SIGNAL_STATUS, {2'h0, fl[4:2], 1'b1, fl[1:0]}, OK);
      for (int j = 8'h37; j <= 8'h3A; j++) wr(8'(j), 8'hFF, 4'h1, OK);
    end
    for (int k = 0; k < 5; k++) begin
      d = (k < 4) ? {4{k[1:0]}} : 8'($urandom);
      foreach (ix[j]) begin
        wr(ix[j], d, 4'h1, OK);
        rd(ix[j], d & mk[j], OK);
      end
    end
    wr(`VSC_IDX_MISSING_BYTE_FILL, ~d, 4'h0, OK);
    rd(`VSC_IDX_MISSING_BYTE_FILL, d, OK);
    wr(8'h30, 8'hFF, 4'h1, BAD);
    wr(8'h3C, 8'hFF, 4'h1, BAD);
    rd(8'h3C, 8'h00, BAD);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`VSC_IDX_MISSING_BYTE_FILL, 8'hA0, OK);
    rd(`VSC_IDX_CLAMP_MODE, 8'h05, OK);
    repeat (3) @(posedge aclk);
    stop_test();
  end
endmodule // vbi_slicer_clamp_regs_test
